// ===== bench/gpio_board.sv
// gpio_board: pin-side circuitry, resolves pad controls into pin levels.
// assumes the bench supplies external drive only on pins it treats as inputs.
`timescale 1ns/10ps
`default_nettype none
module gpio_board (
    input wire logic clk_i,
    input wire gpio_pkg::gpio_pad_t pad_i,
    input wire logic [gpio_pkg::NPIN-1:0] ext_val_i,
    input wire logic [gpio_pkg::NPIN-1:0] ext_en_i,
    output logic [gpio_pkg::NPIN-1:0] pin_o
);
    logic [gpio_pkg::NPIN-1:0] drv;
    logic [gpio_pkg::NPIN-1:0] held;
    logic [gpio_pkg::NPIN-1:0] last_q = '0;
    assign drv = ~pad_i.oe_n;
    assign held = drv | ext_en_i | pad_i.pu;
    // a floating pin shows the inverse of the last level it was held at,
    // steady, so no stale value passes; the release itself flips the level once
    assign pin_o = (drv & pad_i.out) | (~drv & ext_en_i & ext_val_i)
        | (~drv & ~ext_en_i & pad_i.pu) | (~held & ~last_q);
    always @(posedge clk_i) begin
        last_q <= (held & pin_o) | (~held & last_q);
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// testbench: register-level tests of the port block over wishbone.
// assumes the board model closes the loop from pad controls to pin inputs.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    gpio_pkg::gpio_wb_req_t wb_q = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [111:0] pin_w;
    logic [111:0] ext_val = '0;
    logic [111:0] ext_en = '0;
    gpio_pkg::gpio_pad_t pad_o;
    logic irq_o;
    logic [7:0] q;
    logic [111:0] pu_exp;
    int fail_count = 0;
    int checked = 0;
    always #4 clk_i = ~clk_i;
    gpio_top #(.OD_PULLUP(8'h5c)) u_gpio_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_w), .pad_o(pad_o), .irq_o(irq_o));
    gpio_board u_gpio_board (.clk_i(clk_i), .pad_i(pad_o), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pin_o(pin_w));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [111:0] seen, input logic [111:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // bus master: hold the request until ack is sampled, then release for a cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
        end
        q = wb_dat_o[7:0];
        wb_q <= '0;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        pu_exp = '0;
        pu_exp[51:48] = 4'hc;
        pu_exp[75:72] = 4'h5;
        settle();
        chk(pad_o.oe_n, {112{1'b1}});
        chk(pad_o.pu, pu_exp);
        wb(1'b0, 8'hc0, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, 8'h88, 8'hff);
        wb(1'b1, 8'h98, 8'hff);
        settle();
        chk(pad_o.pu[23:16], 8'hff);
        chk(pad_o.pu[55:48], 8'hfc);
        wb(1'b1, 8'h48, 8'h0f);
        settle();
        chk(pad_o.pu[23:16], 8'hf0);
        chk(pad_o.oe_n[23:16], 8'hf0);
        wb(1'b1, 8'h40, 8'hff);
        wb(1'b0, 8'h40, 8'h00);
        settle();
        chk(q, 8'h7e);
        chk(pad_o.oe_n[7:0], 8'h81);
        wb(1'b1, 8'h50, 8'h01);
        wb(1'b0, 8'h50, 8'h00);
        settle();
        chk(q, 8'hff);
        chk(pad_o.oe_n[39:32], 8'h00);
        wb(1'b1, 8'h50, 8'hfe);
        wb(1'b0, 8'h50, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, 8'h58, 8'h0f);
        wb(1'b1, 8'h18, 8'h0a);
        settle();
        chk(pad_o.oe_n[51:48], 4'ha);
        chk(pad_o.out[51:48], 4'h0);
        wb(1'b1, 8'hfc, 8'hff);
        wb(1'b0, 8'hfc, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, 8'h2c, 8'hff);
        wb(1'b0, 8'h2c, 8'h00);
        chk(q, 8'h00);
        // driving port 4 low above was itself a falling edge
        wb(1'b0, 8'hc0, 8'h00);
        chk(q, 8'h01);
        wb(1'b1, 8'hc0, 8'h01);
        wb(1'b0, 8'hc0, 8'h00);
        chk(q, 8'h00);
        // falling edge on one address/data pin, masked first, then unmasked
        @(posedge clk_i);
        ext_en[39:32] <= 8'hff;
        ext_val[39:32] <= 8'hff;
        settle();
        wb(1'b0, 8'h10, 8'h00);
        chk(q, 8'hff);
        @(posedge clk_i);
        ext_val[35] <= 1'b0;
        settle();
        wb(1'b0, 8'hc0, 8'h00);
        chk(q, 8'h01);
        chk(irq_o, 1'b0);
        wb(1'b1, 8'hc4, 8'h01);
        settle();
        chk(irq_o, 1'b1);
        wb(1'b1, 8'hc0, 8'h01);
        settle();
        chk(irq_o, 1'b0);
        wb(1'b0, 8'hc0, 8'h00);
        chk(q, 8'h00);
        @(posedge clk_i);
        ext_en <= '0;
        for (int p = 0; p < 14; p++) begin
            wb(1'b1, 8'h40 + 8'(4 * p), 8'hff);
            wb(1'b1, 8'(4 * p), 8'hff);
        end
        settle();
        chk(112'($countones(~pad_o.oe_n)), 112'd78);
        chk(pad_o.oe_n[75:72], 4'hf);
        chk(pad_o.out[15:8], 8'hff);
        chk(pad_o.out[39:32], 8'hff);
        chk(pad_o.pu[23:16], 8'h00);
        report_and_stop();
    end
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== logic/gpio_pkg.sv
// gpio_pkg: constants, register map and carrier types of the port block.
// assumes one core clock and a synchronous active-high reset.
`default_nettype none
package gpio_pkg;
    localparam int NPORT = 14;
    localparam int NPIN = 112;
    localparam int AD_PORT = 4;
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_DIR = 2'h1;
    localparam logic [1:0] REG_PU = 2'h2;
    localparam logic [1:0] REG_CTL = 2'h3;
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h40;
    localparam logic [7:0] OFS_PU = 8'h80;
    localparam logic [7:0] OFS_STAT = 8'hc0;
    localparam logic [7:0] OFS_MASK = 8'hc4;
    localparam int EV_FALL = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [NPIN-1:0] RST_VEC = '0;
    // bits present per port, port 13 first; port 11 does not exist
    localparam logic [NPIN-1:0] IMPL = {
        8'h03, 8'hff, 8'h00, 8'h0f, 8'h7f, 8'hff, 8'h07,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [NPIN-1:0] IN_ONLY = 112'h81;
    localparam logic [NPIN-1:0] OPEN_DRAIN = {32'h0, 8'h0f, 16'h0, 8'h0f, 48'h0};
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } gpio_wb_req_t;
    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe_n;
        logic [NPIN-1:0] pu;
    } gpio_pad_t;
endpackage
`default_nettype wire

// ===== logic/gpio_top.sv
// gpio_top: general-purpose port pins behind a classic wishbone slave.
// assumes pin inputs are synchronous to clk_i and the pad ring resolves
// out/oe_n/pu into the wire level; pin k of port p is bit 8*p+k.
//
// Summary of operation
// RULE1: port 0 bits 0 and 7 are inputs only, never driven, no direction.
// RULE2: every bidirectional port except port 4 has per-bit direction.
// RULE3: port 4 has one direction bit switching all eight pins together.
// RULE4: a falling edge on any port 4 pin sets the test flag.
// RULE5: cmos pins get software pull-up only while configured as input.
// RULE6: port 6 and port 9 bits 0 to 3 are open-drain.
// RULE7: open-drain pull-ups come from a fixed build option, not software.
// RULE8: seventy-eight cmos bidirectional pins in total.
// RULE9: after reset all pins are inputs, software pull-ups off, test flag clear.
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module gpio_top #(
    parameter logic [7:0] OD_PULLUP = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire gpio_pkg::gpio_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [gpio_pkg::NPIN-1:0] pin_i,
    output gpio_pkg::gpio_pad_t pad_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] byte_of(input logic [gpio_pkg::NPIN-1:0] v,
                                           input logic [3:0] s);
        return v[{s, 3'b000} +: 8];
    endfunction

    // mask-option pull-ups: low nibble port 6, high nibble port 9
    localparam logic [gpio_pkg::NPIN-1:0] OD_PU_VEC =
        {32'h0, 4'h0, OD_PULLUP[7:4], 16'h0, 4'h0, OD_PULLUP[3:0], 48'h0};
    localparam logic [gpio_pkg::NPIN-1:0] CMOS_IO =
        gpio_pkg::IMPL & ~gpio_pkg::IN_ONLY & ~gpio_pkg::OPEN_DRAIN;
    localparam logic [gpio_pkg::NPIN-1:0] BIDIR =
        gpio_pkg::IMPL & ~gpio_pkg::IN_ONLY;

    ////////////////////////////////////////////////////////////////////
    // state

    logic [gpio_pkg::NPIN-1:0] latch_q;
    logic [gpio_pkg::NPIN-1:0] latch_d;
    logic [gpio_pkg::NPIN-1:0] dir_q;
    logic [gpio_pkg::NPIN-1:0] dir_d;
    logic [gpio_pkg::NPIN-1:0] pu_q;
    logic [gpio_pkg::NPIN-1:0] pu_d;
    logic [7:0] ad_prev_q;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;
    gpio_pkg::gpio_pad_t pad_q;
    gpio_pkg::gpio_pad_t pad_d;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    wire req = wb_i.cyc & wb_i.stb;
    // writes land on the edge where the master sees ack, so it never
    // has to guess an earlier commit point
    wire wr_go = req & wb_i.we & ack_q & wb_i.sel[0];
    wire [3:0] slot = wb_i.adr[5:2];
    wire [1:0] region = wb_i.adr[7:6];
    wire slot_ok = (slot < 4'(gpio_pkg::NPORT)) && (byte_of(gpio_pkg::IMPL, slot) != 8'h00);
    wire wr_data = wr_go & (region == gpio_pkg::REG_DATA);
    wire wr_dir = wr_go & (region == gpio_pkg::REG_DIR);
    wire wr_pu = wr_go & (region == gpio_pkg::REG_PU);
    wire wr_stat = wr_go & (wb_i.adr == gpio_pkg::OFS_STAT);
    wire wr_mask = wr_go & (wb_i.adr == gpio_pkg::OFS_MASK);
    wire [7:0] wbyte = wb_i.dat[7:0];

    ////////////////////////////////////////////////////////////////////
    // register next values, one byte lane per port

    for (genvar s = 0; s < gpio_pkg::NPORT; s++) begin : g_port
        localparam logic [3:0] SID = 4'(s);
        localparam logic [7:0] IMP = gpio_pkg::IMPL[8*s +: 8];
        localparam logic [7:0] BID = BIDIR[8*s +: 8];
        localparam logic [7:0] CIO = CMOS_IO[8*s +: 8];
        wire hit = (slot == SID);
        wire [7:0] dir_w;
        if (s == gpio_pkg::AD_PORT) begin : g_ad
            assign dir_w = {8{wbyte[0]}}; // RULE3
        end else begin : g_bw
            assign dir_w = wbyte; // RULE2
        end
        assign latch_d[8*s +: 8] = (wr_data & hit) ? (wbyte & IMP) : latch_q[8*s +: 8];
        // input-only pins never hold a direction bit
        assign dir_d[8*s +: 8] = (wr_dir & hit) ? (dir_w & BID) : dir_q[8*s +: 8]; // RULE1
        // open-drain pins have no software pull-up
        assign pu_d[8*s +: 8] = (wr_pu & hit) ? (wbyte & CIO) : pu_q[8*s +: 8]; // RULE7
    end

    ////////////////////////////////////////////////////////////////////
    // test flag on port 4 falling edges

    wire [7:0] ad_now = byte_of(pin_i, 4'(gpio_pkg::AD_PORT));
    wire fall = |(ad_prev_q & ~ad_now); // RULE4
    // a new edge in the clearing cycle survives the clear
    assign stat_d = ((stat_q & ~({8{wr_stat}} & wbyte)) | {7'h00, fall}) & 8'h01; // RULE4
    assign mask_d = wr_mask ? (wbyte & 8'h01) : mask_q;

    ////////////////////////////////////////////////////////////////////
    // pad drive

    // open-drain pins only ever pull low; cmos pins drive the latch
    assign pad_d.out = latch_q & CMOS_IO; // RULE6
    assign pad_d.oe_n = ~(dir_q & BIDIR & (~gpio_pkg::OPEN_DRAIN | ~latch_q)); // RULE6 RULE8
    assign pad_d.pu = (pu_q & ~dir_q & CMOS_IO) | OD_PU_VEC; // RULE5 RULE7

    ////////////////////////////////////////////////////////////////////
    // read mux

    // outputs read back the latch, inputs read the pin
    wire [gpio_pkg::NPIN-1:0] pin_view = ((dir_q & latch_q) | (~dir_q & pin_i)) & gpio_pkg::IMPL;
    wire [7:0] rd_port =
        (region == gpio_pkg::REG_DATA) ? byte_of(pin_view, slot) :
        (region == gpio_pkg::REG_DIR) ? byte_of(dir_q, slot) :
        byte_of(pu_q, slot);
    wire [7:0] rd_ctl =
        (wb_i.adr == gpio_pkg::OFS_STAT) ? stat_q :
        (wb_i.adr == gpio_pkg::OFS_MASK) ? mask_q : 8'h00;
    wire [7:0] rd_byte =
        (region == gpio_pkg::REG_CTL) ? rd_ctl :
        slot_ok ? rd_port : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // flops

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= gpio_pkg::RST_VEC;
            dir_q <= gpio_pkg::RST_VEC; // RULE9
            pu_q <= gpio_pkg::RST_VEC; // RULE9
            stat_q <= gpio_pkg::RST_BYTE; // RULE9
            mask_q <= gpio_pkg::RST_BYTE;
            ad_prev_q <= gpio_pkg::RST_BYTE;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            pu_q <= pu_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            ad_prev_q <= ad_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            // every address answers; unmapped ones read zero
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                rdat_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_q.out <= gpio_pkg::RST_VEC;
            pad_q.oe_n <= ~gpio_pkg::RST_VEC;
            pad_q.pu <= OD_PU_VEC;
            irq_q <= 1'b0;
        end else begin
            pad_q <= pad_d;
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign pad_o = pad_q;
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // the flag under its own name; software sees it at bit 0 of status
    wire port_fall_edge_test_flag = stat_q[gpio_pkg::EV_FALL];

    property p_in_only;
        pad_q.oe_n[0] && pad_q.oe_n[7] && !dir_q[0] && !dir_q[7];
    endproperty
    a_in_only: assert property (p_in_only) // RULE1
        else $error("input-only pin driven");

    property p_bitwise_dir;
        (wr_dir && slot == 4'h1) |=> dir_q[15:8] == $past(wbyte);
    endproperty
    a_bitwise_dir: assert property (p_bitwise_dir) // RULE2
        else $error("port 1 direction not taken bitwise");

    property p_ad_dir;
        dir_q[39:32] == 8'h00 || dir_q[39:32] == 8'hff;
    endproperty
    a_ad_dir: assert property (p_ad_dir) // RULE3
        else $error("port 4 direction split");

    sequence s_fall_seen;
        fall;
    endsequence
    sequence s_flag_up;
        ##1 port_fall_edge_test_flag ##1 (irq_q == $past(mask_q[0]));
    endsequence
    property p_fall_flag;
        s_fall_seen |-> s_flag_up;
    endproperty
    a_fall_flag: assert property (p_fall_flag) // RULE4
        else $error("falling edge lost");

    property p_pu_input_only;
        ##1 !$past(rst_i) |-> ((pad_q.pu & CMOS_IO) == ($past(pu_q) & ~$past(dir_q) & CMOS_IO));
    endproperty
    a_pu_input_only: assert property (p_pu_input_only) // RULE5
        else $error("pull-up active on output");

    property p_od_low;
        ((pad_q.out & gpio_pkg::OPEN_DRAIN) == '0)
            && ((~pad_q.oe_n & gpio_pkg::OPEN_DRAIN & $past(latch_q)) == '0);
    endproperty
    a_od_low: assert property (p_od_low) // RULE6
        else $error("open-drain pin drove high");

    property p_od_pu_fixed;
        (pad_q.pu & gpio_pkg::OPEN_DRAIN) == OD_PU_VEC && (pu_q & gpio_pkg::OPEN_DRAIN) == '0;
    endproperty
    a_od_pu_fixed: assert property (p_od_pu_fixed) // RULE7
        else $error("open-drain pull-up changed by software");

    property p_cmos_count;
        $countones(CMOS_IO) == 78 && $countones(gpio_pkg::IMPL) == 88;
    endproperty
    a_cmos_count: assert property (p_cmos_count) // RULE8
        else $error("pin count wrong");

    property p_reset_state;
        $fell(rst_i) |-> (dir_q == '0 && pu_q == '0 && stat_q == 8'h00);
    endproperty
    a_reset_state: assert property (@(posedge clk_i) p_reset_state) // RULE9
        else $error("bad state after reset");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held two cycles");

    property p_in_only_pu;
        !pad_q.pu[0] && !pad_q.pu[7] && !pu_q[0] && !pu_q[7];
    endproperty
    a_in_only_pu: assert property (p_in_only_pu) // RULE1
        else $error("input-only pin has a pull-up");

    property p_ad_dir_write;
        (wr_dir && slot == 4'(gpio_pkg::AD_PORT)) |=> dir_q[39:32] == {8{$past(wbyte[0])}};
    endproperty
    a_ad_dir_write: assert property (p_ad_dir_write) // RULE3
        else $error("port 4 direction not copied from bit 0");

    property p_cmos_drive;
        ##1 ((~pad_q.oe_n & CMOS_IO) == ($past(dir_q) & CMOS_IO));
    endproperty
    a_cmos_drive: assert property (p_cmos_drive) // RULE2 RULE8
        else $error("cmos pin drive differs from direction");

    property p_out_latch;
        ##1 ((pad_q.out & CMOS_IO) == ($past(latch_q) & CMOS_IO));
    endproperty
    a_out_latch: assert property (p_out_latch) // RULE8
        else $error("cmos pin level differs from latch");

    property p_od_input_release;
        ##1 ((~pad_q.oe_n & gpio_pkg::OPEN_DRAIN & ~$past(dir_q)) == '0);
    endproperty
    a_od_input_release: assert property (p_od_input_release) // RULE6
        else $error("open-drain input pin driven");

    ////////////////////////////////////////////////////////////////////
    // flag and interrupt checks

    property p_flag_sticky;
        (port_fall_edge_test_flag && !(wr_stat && wbyte[0])) |=> port_fall_edge_test_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // RULE4
        else $error("test flag dropped without a clear");

    property p_flag_clear;
        (wr_stat && wbyte[0] && !fall) |=> !port_fall_edge_test_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // RULE4
        else $error("test flag survived a clear");

    property p_flag_no_spurious;
        (!port_fall_edge_test_flag && !fall) |=> !port_fall_edge_test_flag;
    endproperty
    a_flag_no_spurious: assert property (p_flag_no_spurious) // RULE4
        else $error("test flag set with no falling edge");

    property p_irq_level;
        ##1 (irq_q == $past(port_fall_edge_test_flag && mask_q[0]));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt does not follow masked flag");

    ////////////////////////////////////////////////////////////////////
    // bus handshake checks

    sequence s_req_new;
        req && !ack_q;
    endsequence
    sequence s_ack_once;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_answer;
        s_req_new |-> s_ack_once;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not answered in one cycle");

    property p_dat_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
    endproperty
    a_dat_upper: assert property (p_dat_upper)
        else $error("read data upper lanes not zero");

    property p_reset_pads;
        $fell(rst_i) |-> ((&pad_q.oe_n) && !irq_q && !wb_ack_o);
    endproperty
    a_reset_pads: assert property (@(posedge clk_i) p_reset_pads) // RULE9
        else $error("pads not released after reset");

endmodule
`default_nettype wire
